// [inc/perf_state_pkg.sv]
// constants shared by the performance-state control and feedback block
package perf_state_pkg;
   localparam int unsigned MSR_ADDR_W = 32;
   localparam int unsigned MSR_DATA_W = 64;
   localparam int unsigned OP_POINT_W = 16;
   localparam int unsigned ID_DATA_W = 32;
   // ---------------------------------------------------------------
   // register indices
   // ---------------------------------------------------------------
   localparam logic [31:0] REF_COUNTER_ADDR = 32'h0000_00E7;
   localparam logic [31:0] ACT_COUNTER_ADDR = 32'h0000_00E8;
   localparam logic [31:0] CURRENT_STATE_ADDR = 32'h0000_0198;
   localparam logic [31:0] TARGET_CTRL_ADDR = 32'h0000_0199;
   localparam logic [31:0] MISC_ENABLE_ADDR = 32'h0000_01A0;
   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int unsigned XFER_ENABLE_BIT = 16;
   localparam int unsigned DISENGAGE_BIT = 32;
   localparam logic [63:0] MISC_ENABLE_RESET = 64'h0000_0000_0000_0000;
   localparam logic [15:0] OP_POINT_RESET = 16'h0000;
   localparam logic [63:0] DATA_ZERO = 64'h0000_0000_0000_0000;
   // ---------------------------------------------------------------
   // identification query
   // ---------------------------------------------------------------
   localparam logic [31:0] ID_FEATURE_LEAF = 32'h0000_0001;
   localparam logic [31:0] ID_POWER_LEAF = 32'h0000_0006;
   localparam int unsigned ID_XFER_SUPPORT_BIT = 7;
   localparam int unsigned ID_FEEDBACK_BIT = 0;
   localparam logic [31:0] ID_ONE = 32'h0000_0001;
   localparam logic [31:0] ID_XFER_ECX = ID_ONE << ID_XFER_SUPPORT_BIT;
   localparam logic [31:0] ID_FEEDBACK_ECX = ID_ONE << ID_FEEDBACK_BIT;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SETTLE_TIME_NS = 10000;
   localparam int unsigned SETTLE_CYCLES =
      (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic {STEP_IDLE, STEP_SETTLE} step_state_e;
endpackage

// [src/op_point_stepper.sv]
// moves the applied operating point toward the requested target
`timescale 1ns/10ps
`default_nettype none
module op_point_stepper #(
   parameter int unsigned SETTLE = perf_state_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic xferEnable,
   input wire logic [perf_state_pkg::OP_POINT_W-1:0] targetPoint,
   output logic [perf_state_pkg::OP_POINT_W-1:0] applyPoint,
   output logic [perf_state_pkg::OP_POINT_W-1:0] currentPoint,
   output logic busy
);
   import perf_state_pkg::*;
   step_state_e state_reg, state_next;
   logic [OP_POINT_W-1:0] apply_reg, apply_next, current_reg, current_next;
   logic [15:0] count_reg, count_next;
   logic busy_reg, busy_next;

   always_comb begin
      state_next = state_reg;
      apply_next = apply_reg;
      current_next = current_reg;
      count_next = count_reg;
      case (state_reg)
         STEP_IDLE: begin
            // target sampled only when idle, so late writes queue
            if (xferEnable && targetPoint != current_reg) begin
               apply_next = targetPoint;
               count_next = 16'(SETTLE - 1);
               state_next = STEP_SETTLE;
            end
         end
         STEP_SETTLE: begin
            if (count_reg == 16'h0000) begin
               current_next = apply_reg;
               state_next = STEP_IDLE;
            end else begin
               count_next = count_reg - 16'h0001;
            end
         end
         default: state_next = STEP_IDLE;
      endcase
      busy_next = (state_next == STEP_SETTLE);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= STEP_IDLE;
         apply_reg <= OP_POINT_RESET;
         current_reg <= OP_POINT_RESET;
         count_reg <= 16'h0000;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         apply_reg <= apply_next;
         current_reg <= current_next;
         count_reg <= count_next;
         busy_reg <= busy_next;
      end
   end

   assign applyPoint = apply_reg;
   assign currentPoint = current_reg;
   assign busy = busy_reg;

   a_status_on_arrival: assert property (@(posedge core_clk) disable iff (rst)
      $changed(current_reg) |-> $past(state_reg == STEP_SETTLE && count_reg == 16'h0000))
      else $error("status changed before the point was reached");
   a_settle_done: assert property (@(posedge core_clk) disable iff (rst)
      (busy_reg && count_reg == 16'h0000) |=> !busy_reg && current_reg == $past(apply_reg))
      else $error("status not updated at end of settle");
endmodule // op_point_stepper
`default_nettype wire

// [src/perf_counter_pair.sv]
// reference and actual performance counters of one logical processor
`timescale 1ns/10ps
`default_nettype none
module perf_counter_pair #(
   parameter int unsigned W = perf_state_pkg::MSR_DATA_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic activeExec,
   input wire logic refTick,
   input wire logic deliveredTick,
   input wire logic thermalThrottle,
   input wire logic swThrottle,
   input wire logic wrRef,
   input wire logic wrAct,
   input wire logic [W-1:0] wrData,
   output logic [W-1:0] refCount,
   output logic [W-1:0] actCount
);
   logic [W-1:0] ref_reg, ref_next, act_reg, act_next;
   logic refInc, actInc, wrap;

   function automatic logic [W-1:0] bump(input logic [W-1:0] v, input logic inc);
      bump = inc ? v + W'(1) : v;
   endfunction

   always_comb begin
      refInc = activeExec && refTick;
      actInc = activeExec && deliveredTick && !thermalThrottle && !swThrottle;
      wrap = (refInc && &ref_reg) || (actInc && &act_reg);
      ref_next = wrap ? W'(0) : bump(ref_reg, refInc);
      act_next = wrap ? W'(0) : bump(act_reg, actInc);
      if (wrRef) begin
         ref_next = wrData;
      end
      if (wrAct) begin
         act_next = wrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ref_reg <= '0;
         act_reg <= '0;
      end else begin
         ref_reg <= ref_next;
         act_reg <= act_next;
      end
   end

   assign refCount = ref_reg;
   assign actCount = act_reg;

   a_wrap_clears_both: assert property (@(posedge core_clk) disable iff (rst)
      (actInc && &act_reg && !wrRef && !wrAct) |=> ref_reg == '0 && act_reg == '0)
      else $error("wrap did not clear both counters");
   a_idle_frozen: assert property (@(posedge core_clk) disable iff (rst)
      (!activeExec && !wrRef && !wrAct) |=> $stable(ref_reg) && $stable(act_reg))
      else $error("counter moved outside active state");
   a_throttle_holds: assert property (@(posedge core_clk) disable iff (rst)
      (thermalThrottle && !wrAct && !wrap) |=> $stable(act_reg))
      else $error("actual counter ran while throttled");
   a_write_loads: assert property (@(posedge core_clk) disable iff (rst)
      (wrRef && !wrAct) |=> ref_reg == $past(wrData))
      else $error("reference counter write not taken");
   a_write_independent: assert property (@(posedge core_clk) disable iff (rst)
      (wrRef && !wrAct && !activeExec) |=> $stable(act_reg))
      else $error("actual counter moved on a reference write");
endmodule // perf_counter_pair
`default_nettype wire

// [src/perf_state_control_feedback.sv]
// performance-state control register file and feedback counters
// What this block does
// - identification feature bit 7 advertises transitions
// - enable bit 16 gates transitions, reset clears
// - writing target point starts a transition
// - target written mid-transition applies afterwards
// - control read returns last requested target
// - status read returns point now in effect
// - operating-point code is opaque sixteen bits
// - power leaf bit 0 advertises counters
// - reference counter counts the fixed tick
// - actual counter counts delivered ticks, held while either throttle is on
// - counters per processor, only when active
// - either counter wrapping clears both
// - full 64-bit counters, written independently
// - control bit 32 disengages boost, unmirrored
`timescale 1ns/10ps
`default_nettype none
module perf_state_control_feedback #(
   parameter int unsigned SETTLE = perf_state_pkg::SETTLE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic msrWrite,
   input wire logic msrRead,
   input wire logic [perf_state_pkg::MSR_ADDR_W-1:0] msrAddr,
   input wire logic [perf_state_pkg::MSR_DATA_W-1:0] msrWdata,
   output logic [perf_state_pkg::MSR_DATA_W-1:0] msrRdata,
   output logic msrRdValid,
   output logic msrFault,
   input wire logic idQuery,
   input wire logic [perf_state_pkg::ID_DATA_W-1:0] idLeaf,
   output logic [perf_state_pkg::ID_DATA_W-1:0] idEcx,
   output logic idValid,
   input wire logic activeExec,
   input wire logic refTick,
   input wire logic deliveredTick,
   input wire logic thermalThrottle,
   input wire logic swThrottle,
   output logic [perf_state_pkg::OP_POINT_W-1:0] opPointApply,
   output logic transitionBusy,
   output logic boostDisengage,
   output logic xferEnabled
);
   import perf_state_pkg::*;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic addrIs(input logic [MSR_ADDR_W-1:0] a,
                                   input logic [31:0] r);
      addrIs = (a == r);
   endfunction

   function automatic logic mapped(input logic [MSR_ADDR_W-1:0] a);
      mapped = addrIs(a, REF_COUNTER_ADDR) || addrIs(a, ACT_COUNTER_ADDR) ||
               addrIs(a, CURRENT_STATE_ADDR) || addrIs(a, TARGET_CTRL_ADDR) ||
               addrIs(a, MISC_ENABLE_ADDR);
   endfunction

   logic wrRef, wrAct, wrCtrl, wrMisc, wrBad, rdBad;

   always_comb begin
      wrRef = msrWrite && addrIs(msrAddr, REF_COUNTER_ADDR);
      wrAct = msrWrite && addrIs(msrAddr, ACT_COUNTER_ADDR);
      wrCtrl = msrWrite && addrIs(msrAddr, TARGET_CTRL_ADDR);
      wrMisc = msrWrite && addrIs(msrAddr, MISC_ENABLE_ADDR);
      // status is read only; writing it faults
      wrBad = msrWrite && (!mapped(msrAddr) || addrIs(msrAddr, CURRENT_STATE_ADDR));
      rdBad = msrRead && !mapped(msrAddr);
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [MSR_DATA_W-1:0] misc_reg, misc_next;
   logic [OP_POINT_W-1:0] target_reg, target_next;
   logic disengage_reg, disengage_next;
   logic xferEn_reg, xferEn_next;

   always_comb begin
      misc_next = misc_reg;
      target_next = target_reg;
      disengage_next = disengage_reg;
      if (wrMisc) begin
         misc_next = msrWdata;
      end
      if (wrCtrl) begin
         target_next = msrWdata[OP_POINT_W-1:0];
         disengage_next = msrWdata[DISENGAGE_BIT];
      end
      xferEn_next = misc_next[XFER_ENABLE_BIT];
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         misc_reg <= MISC_ENABLE_RESET;
         target_reg <= OP_POINT_RESET;
         disengage_reg <= 1'b0;
         xferEn_reg <= 1'b0;
      end else begin
         misc_reg <= misc_next;
         target_reg <= target_next;
         disengage_reg <= disengage_next;
         xferEn_reg <= xferEn_next;
      end
   end

   // ---------------------------------------------------------------
   // operating point stepper and counters
   // ---------------------------------------------------------------
   logic [OP_POINT_W-1:0] currentPoint;
   logic [OP_POINT_W-1:0] applyPoint;
   logic stepBusy;
   logic [MSR_DATA_W-1:0] refCount, actCount;

   op_point_stepper #(
      .SETTLE(SETTLE)
   ) stepper (
      .core_clk(core_clk),
      .rst(rst),
      .xferEnable(xferEn_reg),
      .targetPoint(target_reg),
      .applyPoint(applyPoint),
      .currentPoint(currentPoint),
      .busy(stepBusy)
   );

   perf_counter_pair #(
      .W(MSR_DATA_W)
   ) counters (
      .core_clk(core_clk),
      .rst(rst),
      .activeExec(activeExec),
      .refTick(refTick),
      .deliveredTick(deliveredTick),
      .thermalThrottle(thermalThrottle),
      .swThrottle(swThrottle),
      .wrRef(wrRef),
      .wrAct(wrAct),
      .wrData(msrWdata),
      .refCount(refCount),
      .actCount(actCount)
   );

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [MSR_DATA_W-1:0] rdata_reg, rdata_next;
   logic rdValid_reg, rdValid_next;
   logic fault_reg, fault_next;
   logic [MSR_DATA_W-1:0] ctrlView;

   always_comb begin
      ctrlView = MSR_DATA_W'(target_reg);
      ctrlView[DISENGAGE_BIT] = disengage_reg;
      rdata_next = DATA_ZERO;
      if (!msrRead) begin
         rdata_next = rdata_reg;
      end else if (addrIs(msrAddr, REF_COUNTER_ADDR)) begin
         rdata_next = refCount;
      end else if (addrIs(msrAddr, ACT_COUNTER_ADDR)) begin
         rdata_next = actCount;
      end else if (addrIs(msrAddr, TARGET_CTRL_ADDR)) begin
         rdata_next = ctrlView;
      end else if (addrIs(msrAddr, CURRENT_STATE_ADDR)) begin
         rdata_next = MSR_DATA_W'(currentPoint);
      end else if (addrIs(msrAddr, MISC_ENABLE_ADDR)) begin
         rdata_next = misc_reg;
      end
      rdValid_next = msrRead;
      fault_next = rdBad || wrBad;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_reg <= DATA_ZERO;
         rdValid_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rdValid_reg <= rdValid_next;
         fault_reg <= fault_next;
      end
   end

   // ---------------------------------------------------------------
   // identification query
   // ---------------------------------------------------------------
   logic [ID_DATA_W-1:0] idEcx_reg, idEcx_next;
   logic idValid_reg, idValid_next;

   always_comb begin
      idEcx_next = idEcx_reg;
      if (idQuery) begin
         if (idLeaf == ID_FEATURE_LEAF) begin
            idEcx_next = ID_XFER_ECX;
         end else if (idLeaf == ID_POWER_LEAF) begin
            idEcx_next = ID_FEEDBACK_ECX;
         end else begin
            idEcx_next = '0;
         end
      end
      idValid_next = idQuery;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         idEcx_reg <= '0;
         idValid_reg <= 1'b0;
      end else begin
         idEcx_reg <= idEcx_next;
         idValid_reg <= idValid_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign msrRdata = rdata_reg;
   assign msrRdValid = rdValid_reg;
   assign msrFault = fault_reg;
   assign idEcx = idEcx_reg;
   assign idValid = idValid_reg;
   assign opPointApply = applyPoint;
   assign transitionBusy = stepBusy;
   assign boostDisengage = disengage_reg;
   assign xferEnabled = xferEn_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_ctrl_readback: assert property (@(posedge core_clk) disable iff (rst)
      (wrCtrl ##1 (msrRead && !msrWrite && addrIs(msrAddr, TARGET_CTRL_ADDR)))
      |=> rdata_reg[OP_POINT_W-1:0] == $past(msrWdata[OP_POINT_W-1:0], 2)
          && rdata_reg[DISENGAGE_BIT] == $past(msrWdata[DISENGAGE_BIT], 2))
      else $error("control readback differs from last request");
   a_status_unmirrored: assert property (@(posedge core_clk) disable iff (rst)
      (msrRead && addrIs(msrAddr, CURRENT_STATE_ADDR))
      |=> rdValid_reg && rdata_reg[MSR_DATA_W-1:OP_POINT_W] == '0
          && rdata_reg[OP_POINT_W-1:0] == $past(currentPoint))
      else $error("status read wrong");
   a_enable_gate: assert property (@(posedge core_clk) disable iff (rst)
      (!xferEn_reg && !stepBusy) |=> !stepBusy)
      else $error("transition started while disabled");
   a_reset_disables: assert property (@(posedge core_clk)
      rst |=> !xferEn_reg && misc_reg[XFER_ENABLE_BIT] == 1'b0)
      else $error("enable bit survived reset");
   a_start_on_write: assert property (@(posedge core_clk) disable iff (rst)
      (xferEn_reg && !stepBusy && target_reg != currentPoint)
      |=> stepBusy && applyPoint == $past(target_reg))
      else $error("transition did not start toward target");
   a_id_support: assert property (@(posedge core_clk) disable iff (rst)
      (idQuery && idLeaf == ID_FEATURE_LEAF) |=> idValid_reg && idEcx_reg[ID_XFER_SUPPORT_BIT])
      else $error("transition support bit missing");
   a_id_feedback: assert property (@(posedge core_clk) disable iff (rst)
      (idQuery && idLeaf == ID_POWER_LEAF) |=> idValid_reg && idEcx_reg[ID_FEEDBACK_BIT])
      else $error("feedback counter bit missing");
endmodule // perf_state_control_feedback
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the performance-state control and feedback block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
   import perf_state_pkg::*;
   localparam int unsigned SETTLE_TB = 3;
   localparam int unsigned CYCLE_LIMIT = 3000;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic msrWrite = 1'b0;
   logic msrRead = 1'b0;
   logic [MSR_ADDR_W-1:0] msrAddr = '0;
   logic [MSR_DATA_W-1:0] msrWdata = '0;
   logic [MSR_DATA_W-1:0] msrRdata;
   logic msrRdValid;
   logic msrFault;
   logic idQuery = 1'b0;
   logic [ID_DATA_W-1:0] idLeaf = '0;
   logic [ID_DATA_W-1:0] idEcx;
   logic idValid;
   logic activeExec = 1'b0;
   logic refTick = 1'b0;
   logic deliveredTick = 1'b0;
   logic thermalThrottle = 1'b0;
   logic swThrottle = 1'b0;
   logic [OP_POINT_W-1:0] opPointApply;
   logic transitionBusy;
   logic boostDisengage;
   logic xferEnabled;
   int failures = 0;
   int cmpCount = 0;
   int cycles = 0;

   perf_state_control_feedback #(.SETTLE(SETTLE_TB)) u_dut (
      .core_clk(core_clk),
      .rst(rst),
      .msrWrite(msrWrite),
      .msrRead(msrRead),
      .msrAddr(msrAddr),
      .msrWdata(msrWdata),
      .msrRdata(msrRdata),
      .msrRdValid(msrRdValid),
      .msrFault(msrFault),
      .idQuery(idQuery),
      .idLeaf(idLeaf),
      .idEcx(idEcx),
      .idValid(idValid),
      .activeExec(activeExec),
      .refTick(refTick),
      .deliveredTick(deliveredTick),
      .thermalThrottle(thermalThrottle),
      .swThrottle(swThrottle),
      .opPointApply(opPointApply),
      .transitionBusy(transitionBusy),
      .boostDisengage(boostDisengage),
      .xferEnabled(xferEnabled)
   );

   always #25 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles++;
      if (cycles >= CYCLE_LIMIT) begin
         failures++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      if (failures == 0 && cmpCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [31:0] a, input logic [63:0] d, input logic f);
      @(posedge core_clk);
      #1;
      msrWrite = 1'b1;
      msrAddr = a;
      msrWdata = d;
      @(posedge core_clk);
      #1;
      msrWrite = 1'b0;
      `CHK(msrFault, f)
   endtask

   task automatic rd(input logic [31:0] a, input logic [63:0] e, input logic f);
      @(posedge core_clk);
      #1;
      msrRead = 1'b1;
      msrAddr = a;
      @(posedge core_clk);
      #1;
      msrRead = 1'b0;
      `CHK({msrRdValid, msrFault, msrRdata}, {1'b1, f, e})
   endtask

   // write, then read the same index on the very next edge
   task automatic wr_rd(input logic [31:0] a, input logic [63:0] d, input logic [63:0] e);
      @(posedge core_clk);
      #1;
      msrWrite = 1'b1;
      msrAddr = a;
      msrWdata = d;
      @(posedge core_clk);
      #1;
      msrWrite = 1'b0;
      msrRead = 1'b1;
      `CHK(msrFault, 1'b0)
      @(posedge core_clk);
      #1;
      msrRead = 1'b0;
      `CHK({msrRdValid, msrFault, msrRdata}, {1'b1, 1'b0, e})
   endtask

   task automatic id(input logic [31:0] leaf, input logic [31:0] e);
      @(posedge core_clk);
      #1;
      idQuery = 1'b1;
      idLeaf = leaf;
      @(posedge core_clk);
      #1;
      idQuery = 1'b0;
      `CHK({idValid, idEcx}, {1'b1, e})
   endtask

   // n active edges with the given tick and throttle levels
   task automatic run(input int n, input logic r, input logic d, input logic t,
                      input logic s);
      @(posedge core_clk);
      #1;
      activeExec = 1'b1;
      refTick = r;
      deliveredTick = d;
      thermalThrottle = t;
      swThrottle = s;
      repeat (n) @(posedge core_clk);
      #1;
      activeExec = 1'b0;
   endtask

   task automatic settle();
      int n;
      n = 0;
      repeat (3) @(posedge core_clk);
      #1;
      while (transitionBusy !== 1'b0 && n < 50) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 50) begin
         failures++;
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      #1;
      rst = 1'b0;
      `CHK({xferEnabled, transitionBusy, boostDisengage}, 3'b000)
      rd(MISC_ENABLE_ADDR, DATA_ZERO, 1'b0);
      id(ID_FEATURE_LEAF, 32'h0000_0080);
      id(ID_POWER_LEAF, 32'h0000_0001);
      id(32'h0000_0002, 32'h0000_0000);
      // transitions held off while disabled; only power software here
      wr(TARGET_CTRL_ADDR, 64'h0000_0000_0000_0055, 1'b0);
      repeat (6) @(posedge core_clk);
      #1;
      `CHK(transitionBusy, 1'b0)
      rd(CURRENT_STATE_ADDR, DATA_ZERO, 1'b0);
      wr(MISC_ENABLE_ADDR, 64'h0000_0000_0001_0000, 1'b0);
      `CHK(xferEnabled, 1'b1)
      rd(MISC_ENABLE_ADDR, 64'h0000_0000_0001_0000, 1'b0);
      settle();
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_0055, 1'b0);
      // target with disengage bit, read back next edge, status lags
      wr_rd(TARGET_CTRL_ADDR, 64'h0000_0001_0000_1234, 64'h0000_0001_0000_1234);
      `CHK({transitionBusy, boostDisengage}, 2'b11)
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_0055, 1'b0);
      settle();
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_1234, 1'b0);
      `CHK(opPointApply, 16'h1234)
      // second target written mid-transition
      wr(TARGET_CTRL_ADDR, 64'h0000_0000_0000_0A0A, 1'b0);
      wr(TARGET_CTRL_ADDR, 64'h0000_0000_0000_0B0B, 1'b0);
      `CHK({transitionBusy, opPointApply}, {1'b1, 16'h0A0A})
      // status read while the queued target is being applied
      repeat (SETTLE_TB - 1) @(posedge core_clk);
      #1;
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_0A0A, 1'b0);
      `CHK({transitionBusy, opPointApply}, {1'b1, 16'h0B0B})
      rd(TARGET_CTRL_ADDR, 64'h0000_0000_0000_0B0B, 1'b0);
      settle();
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_0B0B, 1'b0);
      `CHK(boostDisengage, 1'b0)
      wr(TARGET_CTRL_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      rd(TARGET_CTRL_ADDR, 64'h0000_0001_0000_FFFF, 1'b0);
      settle();
      rd(CURRENT_STATE_ADDR, 64'h0000_0000_0000_FFFF, 1'b0);
      wr(CURRENT_STATE_ADDR, 64'h0000_0000_0000_0001, 1'b1);
      rd(32'h0000_0010, DATA_ZERO, 1'b1);
      // ----------------------------------------------------------------
      // feedback counters
      // ----------------------------------------------------------------
      refTick = 1'b1;
      deliveredTick = 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      rd(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      rd(ACT_COUNTER_ADDR, DATA_ZERO, 1'b0);
      run(7, 1'b1, 1'b1, 1'b0, 1'b0);
      run(4, 1'b1, 1'b1, 1'b1, 1'b0);
      run(2, 1'b1, 1'b1, 1'b0, 1'b1);
      run(3, 1'b1, 1'b0, 1'b0, 1'b0);
      rd(REF_COUNTER_ADDR, 64'h0000_0000_0000_0010, 1'b0);
      rd(ACT_COUNTER_ADDR, 64'h0000_0000_0000_0007, 1'b0);
      wr(REF_COUNTER_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      rd(REF_COUNTER_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      rd(ACT_COUNTER_ADDR, 64'h0000_0000_0000_0007, 1'b0);
      wr(ACT_COUNTER_ADDR, 64'h0000_0000_0000_0005, 1'b0);
      run(1, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge core_clk);
      rd(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      rd(ACT_COUNTER_ADDR, DATA_ZERO, 1'b0);
      run(2, 1'b1, 1'b1, 1'b0, 1'b0);
      rd(REF_COUNTER_ADDR, 64'h0000_0000_0000_0002, 1'b0);
      // window start: each counter zeroed by its own write
      wr(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      wr(ACT_COUNTER_ADDR, DATA_ZERO, 1'b0);
      rd(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      rd(ACT_COUNTER_ADDR, DATA_ZERO, 1'b0);
      run(3, 1'b1, 1'b1, 1'b0, 1'b0);
      rd(REF_COUNTER_ADDR, 64'h0000_0000_0000_0003, 1'b0);
      wr(ACT_COUNTER_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      run(1, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (2) @(posedge core_clk);
      rd(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      rd(ACT_COUNTER_ADDR, DATA_ZERO, 1'b0);
      // reset after a counter write clears enable, control and the reference counter
      wr(REF_COUNTER_ADDR, 64'h0000_0000_0000_0009, 1'b0);
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      `CHK({xferEnabled, transitionBusy, boostDisengage}, 3'b000)
      rd(MISC_ENABLE_ADDR, DATA_ZERO, 1'b0);
      rd(TARGET_CTRL_ADDR, DATA_ZERO, 1'b0);
      rd(REF_COUNTER_ADDR, DATA_ZERO, 1'b0);
      conclude();
   end
endmodule // tb
`default_nettype wire
